// ---- scp_pkg.sv ----
/*
 * Constants and types shared by both ends of the serial configuration port
 * and its power-down and channel-averaging control.
 * Assumes one 100 MHz system clock on each end; the link clock is sampled.
 */
package scp_pkg;

   // ==========================================================
   // Frame layout
   localparam int FRAME_BITS    = 24;
   localparam int ADDR_BITS     = 12;
   localparam int DATA_BITS     = 8;
   localparam int RW_POS        = 23;
   localparam int ADDR_MSB      = 19;
   localparam int DATA_PHASE_AT = 16;
   localparam int CNT_W         = 5;

   // ==========================================================
   // Register addresses and fields
   localparam logic [11:0] ADDR_PDN       = 12'h008;
   localparam logic [11:0] ADDR_PDN_LANE  = 12'h009;
   localparam logic [11:0] ADDR_MASK      = 12'h00D;
   localparam logic [11:0] ADDR_AVG       = 12'h024;
   localparam int PDN_GLOBAL_POS  = 0;
   localparam int PDN_B_POS       = 1;
   localparam int PDN_A_POS       = 2;
   localparam int PDN_REFAMP_POS  = 4;
   localparam int PDN_CLKBUF_POS  = 5;
   localparam int MASK_BG_POS     = 1;
   localparam int MASK_REFAMP_POS = 2;
   localparam int MASK_CLKBUF_POS = 3;
   localparam int AVG_EN_POS      = 5;
   localparam int AVG_MUX_POS     = 3;
   localparam logic [7:0] RST_VAL = 8'h00;

   // ==========================================================
   // Timing
   localparam int SYS_CLK_MHZ     = 100;
   localparam int SCLK_MAX_MHZ    = 12;
   localparam int HOST_HALF_MIN   = (SYS_CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
   // Read bits need six clocks back through both synchronisers; two spare
   localparam int LINK_LAG_CYC    = 8;
   localparam int HOST_HALF_CYC   = (HOST_HALF_MIN > LINK_LAG_CYC) ? HOST_HALF_MIN : LINK_LAG_CYC;
   localparam int SAMPLE_TIMEOUT  = 16;
   localparam int SAMP_W          = 5;
   localparam int CONV_W          = 16;

   typedef enum logic [1:0] {
      SCP_IDLE  = 2'b00,
      SCP_SHIFT = 2'b01,
      SCP_DONE  = 2'b10
   } scp_host_state_type;

   function automatic logic [7:0] scp_set(input logic [7:0] v, input int pos);
      scp_set = v | (8'h01 << pos);
   endfunction : scp_set

endpackage : scp_pkg

// ---- scp_if.sv ----
/*
 * Serial configuration link between host and converter.
 * Assumes the bench resolves the shared data line from the two enables.
 */
`timescale 1ns/100ps
`default_nettype none
interface scp_if;
   logic serial_enable_n;
   logic sclk;
   logic sdio_host_o;
   logic sdio_host_oe;
   logic sdio_dev_o;
   logic sdio_dev_oe;
   logic sdio;

   modport dev  (input serial_enable_n, sclk, sdio, output sdio_dev_o, sdio_dev_oe);
   modport host (output serial_enable_n, sclk, sdio_host_o, sdio_host_oe, input sdio);
endinterface : scp_if
`default_nettype wire

// ---- scp_dev.sv ----
/*
 * Converter end: serial register port, power-down control, channel averaging.
 * Assumes serial pins and the sampling clock come from outside clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
module scp_dev (
   // System
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Link
   scp_if.dev                    link,
   // Pins and converter side
   input  wire logic             global_sleep_pin,
   input  wire logic             sample_clk,
   input  wire logic [15:0]      conv_a,
   input  wire logic [15:0]      conv_b,
   // Power and data outputs
   output logic                  sleep_active,
   output logic                  chan_a_off,
   output logic                  chan_b_off,
   output logic                  refamp_off,
   output logic                  clkbuf_off,
   output logic                  bandgap_off,
   output logic [5:0]            lane_off,
   output logic [15:0]           lane_a_data,
   output logic [15:0]           ddc_in_data,
   output logic                  ddc_in_valid
);

   typedef struct packed {
      logic [1:0]  sen_s;
      logic [1:0]  sclk_s;
      logic [1:0]  sdi_s;
      logic [1:0]  pin_s;
      logic [1:0]  smp_s;
      logic        sclk_prev;
      logic        smp_prev;
      logic [4:0]  samp_cnt;
      logic        smp_alive;
      logic [4:0]  bit_cnt;
      logic [23:0] shift;
      logic [7:0]  rd_data;
      logic        rd_phase;
      logic        rd_drive;
      logic        sdo;
      logic [7:0]  pdn;
      logic [7:0]  pdn_lane;
      logic [7:0]  mask;
      logic [7:0]  avg;
      logic        sleep;
      logic [15:0] lane_a;
      logic [15:0] ddc;
      logic        ddc_v;
   } scp_dev_state_type;

   scp_dev_state_type s_q;
   scp_dev_state_type s_d;

   function automatic logic [7:0] reg_read(input scp_dev_state_type s, input logic [11:0] a);
      unique case (a)
         scp_pkg::ADDR_PDN:      reg_read = s.pdn;
         scp_pkg::ADDR_PDN_LANE: reg_read = s.pdn_lane;
         scp_pkg::ADDR_MASK:     reg_read = s.mask;
         scp_pkg::ADDR_AVG:      reg_read = s.avg;
         default:                reg_read = scp_pkg::RST_VAL;
      endcase
   endfunction : reg_read

   logic        rise;
   logic        fall;
   logic [23:0] nxt_shift;
   logic [16:0] avg_sum;
   logic        sleep_req;

   always_comb begin
      s_d = s_q;
      // Two-flop synchronisers; only the second stage is read
      s_d.sen_s  = {s_q.sen_s[0], link.serial_enable_n};
      s_d.sclk_s = {s_q.sclk_s[0], link.sclk};
      s_d.sdi_s  = {s_q.sdi_s[0], link.sdio};
      s_d.pin_s  = {s_q.pin_s[0], global_sleep_pin};
      s_d.smp_s  = {s_q.smp_s[0], sample_clk};
      s_d.sclk_prev = s_q.sclk_s[1];
      s_d.smp_prev  = s_q.smp_s[1];
      // Edge detection on sclk holds for any slow rate while each sclk phase lasts at least one clk_sys cycle
      rise = s_q.sclk_s[1] & ~s_q.sclk_prev;
      fall = ~s_q.sclk_s[1] & s_q.sclk_prev;
      nxt_shift = {s_q.shift[22:0], s_q.sdi_s[1]};

      if (s_q.sen_s[1]) begin
         s_d.bit_cnt  = '0;
         s_d.rd_phase = 1'b0;
         s_d.rd_drive = 1'b0;
      end else if (rise) begin
         s_d.shift = nxt_shift;
         if (s_q.bit_cnt == 5'(scp_pkg::FRAME_BITS - 1)) begin
            s_d.bit_cnt  = '0;
            s_d.rd_phase = 1'b0;
            s_d.rd_drive = 1'b0;
            if (!nxt_shift[scp_pkg::RW_POS]) begin
               unique case (nxt_shift[scp_pkg::ADDR_MSB -: scp_pkg::ADDR_BITS])
                  scp_pkg::ADDR_PDN:      s_d.pdn      = nxt_shift[7:0];
                  scp_pkg::ADDR_PDN_LANE: s_d.pdn_lane = nxt_shift[7:0];
                  scp_pkg::ADDR_MASK:     s_d.mask     = nxt_shift[7:0];
                  scp_pkg::ADDR_AVG:      s_d.avg      = nxt_shift[7:0];
                  default:                ;
               endcase
            end
         end else begin
            s_d.bit_cnt = s_q.bit_cnt + 5'd1;
            if (s_q.bit_cnt == 5'(scp_pkg::DATA_PHASE_AT - 1) && nxt_shift[15]) begin
               s_d.rd_phase = 1'b1;
               s_d.rd_data  = reg_read(s_q, nxt_shift[11:0]);
            end
         end
      end else if (fall && s_q.rd_phase) begin
         // Drive starts at the first fall so the host has released the line
         s_d.rd_drive = 1'b1;
         s_d.sdo     = s_q.rd_data[7];
         s_d.rd_data = {s_q.rd_data[6:0], 1'b0};
      end

      // Sampling clock seen toggling recently
      if (s_q.smp_s[1] != s_q.smp_prev) begin
         s_d.samp_cnt  = '0;
         s_d.smp_alive = 1'b1;
      end else if (s_q.samp_cnt == 5'(scp_pkg::SAMPLE_TIMEOUT)) begin
         s_d.smp_alive = 1'b0;
      end else begin
         s_d.samp_cnt = s_q.samp_cnt + 5'd1;
      end

      sleep_req = s_q.pin_s[1] | s_q.pdn[scp_pkg::PDN_GLOBAL_POS];
      if (s_q.smp_alive) begin
         s_d.sleep = sleep_req;
      end

      // Averaging: arithmetic mean of signed samples
      avg_sum = {conv_a[15], conv_a} + {conv_b[15], conv_b};
      s_d.ddc_v = 1'b0;
      if (s_q.avg[scp_pkg::AVG_EN_POS]) begin
         if (s_q.avg[scp_pkg::AVG_MUX_POS]) begin
            s_d.ddc   = avg_sum[16:1];
            s_d.ddc_v = 1'b1;
            s_d.lane_a = conv_a;
         end else begin
            s_d.lane_a = avg_sum[16:1];
         end
      end else begin
         s_d.lane_a = conv_a;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q          <= '0;
         s_q.sen_s    <= 2'b11;
         s_q.pin_s    <= 2'b00;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   assign link.sdio_dev_o  = s_q.sdo;
   assign link.sdio_dev_oe = s_q.rd_drive & ~s_q.sen_s[1];
   assign sleep_active = s_q.sleep;
   assign chan_a_off   = s_q.sleep | s_q.pdn[scp_pkg::PDN_A_POS];
   assign chan_b_off   = s_q.sleep | s_q.pdn[scp_pkg::PDN_B_POS];
   // Masked blocks follow sleep; otherwise reference amp and clock buffer follow only their own bit, and the bandgap, having none, stays on
   assign refamp_off  = s_q.pdn[scp_pkg::PDN_REFAMP_POS]
                      | (s_q.sleep & s_q.mask[scp_pkg::MASK_REFAMP_POS]);
   assign clkbuf_off  = s_q.pdn[scp_pkg::PDN_CLKBUF_POS]
                      | (s_q.sleep & s_q.mask[scp_pkg::MASK_CLKBUF_POS]);
   assign bandgap_off = s_q.sleep & s_q.mask[scp_pkg::MASK_BG_POS];
   assign lane_off     = s_q.pdn_lane[5:0];
   assign lane_a_data  = s_q.lane_a;
   assign ddc_in_data  = s_q.ddc;
   assign ddc_in_valid = s_q.ddc_v;

endmodule : scp_dev
`default_nettype wire

// ---- scp_host.sv ----
/*
 * Host end: drives one 24-bit write or read frame per request.
 * Assumes the device answers reads on the shared data line.
 */
`timescale 1ns/100ps
`default_nettype none
module scp_host (
   // System
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Link
   scp_if.host              link,
   // Request
   input  wire logic        req_valid,
   input  wire logic        req_read,
   input  wire logic [11:0] req_addr,
   input  wire logic [7:0]  req_wdata,
   output logic             req_ready,
   // Answer
   output logic             rsp_valid,
   output logic [7:0]       rsp_rdata
);

   typedef struct packed {
      scp_pkg::scp_host_state_type st;
      logic [1:0]  sdi_s;
      logic [23:0] sh;
      logic [4:0]  bits;
      logic [3:0]  div;
      logic        sclk;
      logic        rd;
      logic [7:0]  rdat;
      logic        rv;
   } scp_host_reg_type;

   scp_host_reg_type h_q;
   scp_host_reg_type h_d;

   always_comb begin
      h_d = h_q;
      h_d.sdi_s = {h_q.sdi_s[0], link.sdio};
      h_d.rv = 1'b0;
      unique case (h_q.st)
         scp_pkg::SCP_IDLE: begin
            if (req_valid) begin
               h_d.sh   = {req_read, 3'b000, req_addr, req_wdata};
               h_d.rd   = req_read;
               h_d.bits = '0;
               h_d.div  = '0;
               h_d.sclk = 1'b0;
               h_d.st   = scp_pkg::SCP_SHIFT;
            end
         end
         scp_pkg::SCP_SHIFT: begin
            h_d.div = h_q.div + 4'd1;
            if (h_q.div == 4'(scp_pkg::HOST_HALF_CYC - 1)) begin
               h_d.div  = '0;
               h_d.sclk = ~h_q.sclk;
               if (h_q.sclk) begin
                  h_d.sh   = {h_q.sh[22:0], 1'b0};
                  h_d.bits = h_q.bits + 5'd1;
                  if (h_q.bits == 5'(scp_pkg::FRAME_BITS - 1)) begin
                     h_d.st = scp_pkg::SCP_DONE;
                  end
               end else if (h_q.rd && h_q.bits >= 5'(scp_pkg::DATA_PHASE_AT)) begin
                  h_d.rdat = {h_q.rdat[6:0], h_q.sdi_s[1]};
               end
            end
         end
         scp_pkg::SCP_DONE: begin
            h_d.rv = 1'b1;
            h_d.st = scp_pkg::SCP_IDLE;
         end
         default: h_d.st = scp_pkg::SCP_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         h_q    <= '0;
         h_q.st <= scp_pkg::SCP_IDLE;
      end else begin
         h_q <= h_d;
      end
   end

   assign link.serial_enable_n = (h_q.st != scp_pkg::SCP_SHIFT);
   assign link.sclk            = h_q.sclk;
   assign link.sdio_host_o     = h_q.sh[23];
   assign link.sdio_host_oe    = (h_q.st == scp_pkg::SCP_SHIFT)
                                 && !(h_q.rd && h_q.bits >= 5'(scp_pkg::DATA_PHASE_AT));
   assign req_ready = (h_q.st == scp_pkg::SCP_IDLE);
   assign rsp_valid = h_q.rv;
   assign rsp_rdata = h_q.rdat;

endmodule : scp_host
`default_nettype wire

// ---- scp_checker.sv ----
/*
 * Checker for the serial link between the host end and the converter end.
 * Assumes both ends run on clk_sys and the host drives sclk from registers.
 */
`timescale 1ns/100ps
`default_nettype none
module scp_checker (
   // System
   input wire logic clk_sys,
   input wire logic rst,
   // Link
   input wire logic serial_enable_n,
   input wire logic sclk,
   input wire logic sdio_host_o,
   input wire logic sdio_host_oe,
   input wire logic sdio_dev_o,
   input wire logic sdio_dev_oe,
   input wire logic sdio
);
   // ==========================================================
   // Rising serial edges counted within one enable-low period
   logic       sclk_q;
   logic [4:0] cnt_q;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b0;
         cnt_q  <= 5'h00;
      end else begin
         sclk_q <= sclk;
         cnt_q  <= serial_enable_n ? 5'h00 : cnt_q + {4'h0, sclk & ~sclk_q};
      end
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_high_half;
      sclk [*8] ##1 !sclk;
   endsequence
   sequence s_low_half;
      !sclk [*8];
   endsequence

   a_no_contention: assert property (!(sdio_host_oe && sdio_dev_oe))
      else $error("Both ends drive the data line");
   a_idle_no_drive: assert property (serial_enable_n [*8] |-> !sdio_dev_oe)
      else $error("Device drives data line while idle");
   a_dev_oe_phase: assert property ($rose(sdio_dev_oe) |-> cnt_q == 5'h10)
      else $error("Device drive starts outside the data phase");
   a_dev_on_fall: assert property
      (sdio_dev_oe && $past(sdio_dev_oe) && $changed(sdio_dev_o) |-> !sclk)
      else $error("Read data changed while serial clock high");
   a_frame_count: assert property ($rose(serial_enable_n) |-> cnt_q == 5'h18)
      else $error("Frame length differs from 24 rising edges");
   a_idle_sclk: assert property (serial_enable_n |-> !sclk)
      else $error("Serial clock not idle low");
   a_sclk_high: assert property ($rose(sclk) |-> s_high_half)
      else $error("Serial clock high phase wrong");
   a_sclk_low: assert property ($fell(sclk) |-> s_low_half)
      else $error("Serial clock low phase too short");
   a_host_hold: assert property ($rose(sclk) && sdio_host_oe |-> $stable(sdio_host_o))
      else $error("Host data moved at serial clock rise");
endmodule : scp_checker
`default_nettype wire

// ---- tb_top.sv ----
/*
 * Testbench: host and converter ends joined, plus a second converter fed
 * by a bench driver. Assumes the package and interface are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct packed {logic rd; logic [11:0] a; logic [7:0] wd; logic [7:0] ex;} scp_row_type;
   logic        clk_sys, rst, pin, smp_on, smp_clk, d2;
   logic        req_valid, req_read, req_ready, rsp_valid, ddc_valid;
   logic [11:0] req_addr;
   logic [7:0]  req_wdata, rsp_rdata;
   logic [15:0] conv_a, conv_b, lane_a, ddc_data;
   logic [5:0]  lane_off, lane_off2, offs;
   logic [23:0] cap;
   int          n_errors, compares;
   scp_row_type rows [8] = '{
      '{1'b0, 12'h009, 8'h2A, 8'h00},
      '{1'b1, 12'h009, 8'hFF, 8'h2A},
      '{1'b1, 12'h009, 8'h00, 8'h2A},
      '{1'b0, 12'h00D, 8'h0E, 8'h00},
      '{1'b1, 12'h00D, 8'h00, 8'h0E},
      '{1'b1, 12'h123, 8'h00, 8'h00},
      '{1'b0, 12'h024, 8'h20, 8'h00},
      '{1'b1, 12'h024, 8'h00, 8'h20}};

   scp_if link ();
   scp_if link2 ();
   // Undriven data line floats so a missing drive never reads as a match
   assign link.sdio = link.sdio_dev_oe ? link.sdio_dev_o
                    : link.sdio_host_oe ? link.sdio_host_o : 1'bz;
   assign link2.sdio = link2.sdio_dev_oe ? link2.sdio_dev_o : d2;

   scp_host u_scp_host (.clk_sys, .rst, .link(link.host), .req_valid, .req_read, .req_addr,
      .req_wdata, .req_ready, .rsp_valid, .rsp_rdata);
   scp_dev u_scp_dev (.clk_sys, .rst, .link(link.dev), .global_sleep_pin(pin),
      .sample_clk(smp_clk), .conv_a, .conv_b, .sleep_active(offs[5]), .chan_a_off(offs[4]),
      .chan_b_off(offs[3]), .refamp_off(offs[2]), .clkbuf_off(offs[1]),
      .bandgap_off(offs[0]), .lane_off, .lane_a_data(lane_a), .ddc_in_data(ddc_data),
      .ddc_in_valid(ddc_valid));
   scp_dev u_scp_dev_2 (.clk_sys, .rst, .link(link2.dev), .global_sleep_pin(1'b0),
      .sample_clk(smp_clk), .conv_a, .conv_b, .sleep_active(), .chan_a_off(), .chan_b_off(),
      .refamp_off(), .clkbuf_off(), .bandgap_off(), .lane_off(lane_off2), .lane_a_data(),
      .ddc_in_data(), .ddc_in_valid());
   scp_checker u_scp_checker (.clk_sys, .rst, .serial_enable_n(link.serial_enable_n),
      .sclk(link.sclk), .sdio_host_o(link.sdio_host_o), .sdio_host_oe(link.sdio_host_oe),
      .sdio_dev_o(link.sdio_dev_o), .sdio_dev_oe(link.sdio_dev_oe), .sdio(link.sdio));

   // ==========================================================
   // Clocks and wire capture
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always #20 if (smp_on) smp_clk = ~smp_clk;
   always @(posedge link.sclk) if (!link.serial_enable_n) cap <= {cap[22:0], link.sdio};

   // ==========================================================
   // Tasks
   task automatic chk_data(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t serial data %h expected %h", $time, got, exp);
      end
   endtask : chk_data

   task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t output %h expected %h", $time, got, exp);
      end
   endtask : chk_out

   task automatic xfer(input scp_row_type r);
      int i = 0;
      @(negedge clk_sys);
      req_valid = 1'b1;
      req_read  = r.rd;
      req_addr  = r.a;
      req_wdata = r.wd;
      while (req_ready !== 1'b1 && i < 1000) begin
         @(negedge clk_sys);
         i++;
      end
      if (i >= 1000) begin
         n_errors++;
         $display("CHECK FAILED %0t request never accepted", $time);
      end
      @(negedge clk_sys);
      req_valid = 1'b0;
      i = 0;
      while (rsp_valid !== 1'b1 && i < 1000) begin
         @(negedge clk_sys);
         i++;
      end
      if (i >= 1000) begin
         n_errors++;
         $display("CHECK FAILED %0t frame never finished", $time);
      end
      chk_data(cap, {r.rd, 3'h0, r.a, r.rd ? r.ex : r.wd});
      if (r.rd) chk_data({16'h0000, rsp_rdata}, {16'h0000, r.ex});
   endtask : xfer

   // Bench driver: short high phase, 80 ns period
   task automatic drv(input logic [23:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         d2 = w[23 - i];
         repeat (5) @(negedge clk_sys);
         link2.sclk = 1'b1;
         repeat (3) @(negedge clk_sys);
         link2.sclk = 1'b0;
      end
      repeat (6) @(negedge clk_sys);
   endtask : drv

   task automatic results;
      $display("n_errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   // ==========================================================
   // Sequence
   initial begin
      #500000;
      n_errors++;
      results();
   end

   initial begin
      {rst, link2.serial_enable_n} = 2'b11;
      {pin, smp_clk, req_valid, req_read, d2, link2.sclk} = 6'h00;
      {link2.sdio_host_o, link2.sdio_host_oe} = 2'b00;
      smp_on = 1'b1;
      req_addr = 12'h000;
      req_wdata = 8'h00;
      conv_a = 16'h8010;
      conv_b = 16'h0FF0;
      n_errors = 0;
      compares = 0;
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys) rst = 1'b0;
      foreach (rows[k]) xfer(rows[k]);
      chk_out({10'h000, lane_off}, 16'h002A);
      chk_out(lane_a, 16'hC800);
      xfer('{1'b0, 12'h024, 8'h28, 8'h00});
      repeat (20) @(negedge clk_sys);
      chk_out(ddc_data, 16'hC800);
      chk_out({15'h0000, ddc_valid}, 16'h0001);
      pin = 1'b1;
      repeat (20) @(negedge clk_sys);
      chk_out({10'h000, offs}, 16'h003F);
      pin = 1'b0;
      repeat (20) @(negedge clk_sys);
      chk_out({10'h000, offs}, 16'h0000);
      smp_on = 1'b0;
      repeat (30) @(negedge clk_sys);
      pin = 1'b1;
      repeat (20) @(negedge clk_sys);
      chk_out({10'h000, offs}, 16'h0000);
      smp_on = 1'b1;
      repeat (20) @(negedge clk_sys);
      chk_out({10'h000, offs}, 16'h003F);
      xfer('{1'b0, 12'h00D, 8'h00, 8'h00});
      // Reference amp is dropped by its own power-down bit; with the mask cleared, sleep leaves it on
      xfer('{1'b0, 12'h008, 8'h16, 8'h00});
      repeat (20) @(negedge clk_sys);
      chk_out({10'h000, offs}, 16'h003C);
      xfer('{1'b0, 12'h008, 8'h01, 8'h00});
      pin = 1'b0;
      repeat (20) @(negedge clk_sys);
      chk_out({10'h000, offs}, 16'h0038);
      link2.serial_enable_n = 1'b0;
      drv(24'h00911, 24);
      chk_out({10'h000, lane_off2}, 16'h0011);
      drv(24'h00922, 24);
      chk_out({10'h000, lane_off2}, 16'h0022);
      drv(24'h00933, 12);
      link2.serial_enable_n = 1'b1;
      repeat (10) @(negedge clk_sys);
      chk_out({10'h000, lane_off2}, 16'h0022);
      drv(24'h00944, 24);
      chk_out({10'h000, lane_off2}, 16'h0022);
      link2.serial_enable_n = 1'b0;
      drv(24'h0093C, 24);
      chk_out({10'h000, lane_off2}, 16'h003C);
      link2.serial_enable_n = 1'b1;
      results();
   end
endmodule : tb_top
`default_nettype wire
